// ### hw/smsf_pkg.sv
// Shared constants and types for the serial memory front end and its master
package smsf_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 19;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [1:0] ADDR_BYTE_FIRST = 2'h0;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_WR_MEM = 8'h02;
    localparam logic [7:0] OP_RD_MEM = 8'h03;

    // ****************************************************************
    // Status register layout
    // ****************************************************************
    localparam int STAT_PPE_BIT = 7;
    localparam int STAT_WEL_BIT = 1;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_WR_MASK = 8'h8c;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCK_MAX_MHZ = 50;
    localparam int SCK_PERIOD_NS = 800;
    localparam int SCK_HALF_CYC = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int SYNC_W = 3;

    typedef enum logic [6:0] {
        SMSF_IDLE = 7'b0000001,
        SMSF_OPC = 7'b0000010,
        SMSF_ADR = 7'b0000100,
        SMSF_DAT = 7'b0001000,
        SMSF_WSR = 7'b0010000,
        SMSF_RD = 7'b0100000,
        SMSF_IGN = 7'b1000000
    } smsf_dev_state_t;

    typedef enum logic [5:0] {
        SMSF_M_IDLE = 6'b000001,
        SMSF_M_WAIT = 6'b000010,
        SMSF_M_SETUP = 6'b000100,
        SMSF_M_LOW = 6'b001000,
        SMSF_M_HIGH = 6'b010000,
        SMSF_M_HOLD = 6'b100000
    } smsf_mst_state_t;

endpackage

// ### hw/smsf_link_if.sv
// Serial link between the memory front end and its master
`timescale 1ns/1ps
interface smsf_link_if;
    logic cs_b;
    logic sck;
    logic mosi;
    logic so_o;
    logic so_oe;
    logic wp_b;
    logic miso;

    // Released output line reads high, as through a pull-up
    assign miso = so_oe ? so_o : 1'b1;

    modport dev (
        input cs_b,
        input sck,
        input mosi,
        input wp_b,
        output so_o,
        output so_oe
    );

    modport mst (
        output cs_b,
        output sck,
        output mosi,
        output wp_b,
        input miso
    );
endinterface

// ### hw/smsf_device.sv
// Slave end: memory array, status register and serial command decoder
`timescale 1ns/1ps

// Contract
// R01: Deselected: standby, inputs ignored, output released
// R02: Opcode only after fresh select falling edge
// R03: Sample on rising, drive on falling
// R04: Any clock rate; pauses keep state
// R05: Data input looked at only on rise
// R06: Output driven only while returning read data
// R07: Pin-protected status register refuses writes
// R08: 19-bit address, five top bits ignored
// R09: Writes complete at bus speed, never busy
// R10: Only modes 0 and 3 supported
// R11: Capture starts first rise after select
// R12: Opcode, then address, then data bytes
// R13: Master deselects between commands
// R14: Pure slave, never starts transfers
// R15: Master selects and makes the clock
// R16: Never drive output while receiving
// R17: Most significant bit first everywhere
// R18: Clock level at select picks mode
// R19: Unknown opcode: ignore rest, stay released
// R20: Deselect mid-command abandons and clears counters
module smsf_device import smsf_pkg::*; #(
    parameter int AW = ADDR_W
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    smsf_link_if.dev link,
    output logic [7:0] status_q_o,
    output logic mode3_o
);

    typedef struct packed {
        logic [SYNC_W-1:0] sck_sy;
        logic [SYNC_W-1:0] cs_sy;
        logic [SYNC_W-1:0] si_sy;
        logic [SYNC_W-1:0] wp_sy;
        logic sck_f;
        logic cs_f;
        logic si_f;
        logic wp_f;
        smsf_dev_state_t state;
        logic mode3;
        logic [6:0] rx;
        logic [2:0] bcnt;
        logic [1:0] acnt;
        logic [AW-1:0] addr;
        logic is_wr;
        logic rd_stat;
        logic [7:0] tx;
        logic [2:0] fcnt;
        logic [7:0] status;
        logic so;
        logic oe;
    } smsf_dev_t;

    smsf_dev_t q;
    smsf_dev_t d;
    logic [7:0] mem [0:(2**AW)-1];
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic sck_n;
        logic cs_n;
        logic si_n;
        logic rise;
        logic fall;
        logic [7:0] b;
        logic [AW-1:0] a;
        sck_n = q.sck_f;
        cs_n = q.cs_f;
        si_n = q.si_f;
        b = 8'h00;
        a = q.addr;
        rise = 1'b0;
        fall = 1'b0;
        d = q;
        mem_we = 1'b0;
        mem_wa = q.addr;
        mem_wd = 8'h00;

        // Pin changes count only once the second and third stages agree
        d.sck_sy = {q.sck_sy[SYNC_W-2:0], link.sck};
        d.cs_sy = {q.cs_sy[SYNC_W-2:0], link.cs_b};
        d.si_sy = {q.si_sy[SYNC_W-2:0], link.mosi};
        d.wp_sy = {q.wp_sy[SYNC_W-2:0], link.wp_b};
        if (q.sck_sy[1] == q.sck_sy[2]) begin
            sck_n = q.sck_sy[2];
        end
        if (q.cs_sy[1] == q.cs_sy[2]) begin
            cs_n = q.cs_sy[2];
        end
        if (q.si_sy[1] == q.si_sy[2]) begin
            si_n = q.si_sy[2];
        end
        if (q.wp_sy[1] == q.wp_sy[2]) begin
            d.wp_f = q.wp_sy[2];
        end
        d.sck_f = sck_n;
        d.cs_f = cs_n;
        d.si_f = si_n;
        rise = sck_n & ~q.sck_f;
        fall = ~sck_n & q.sck_f;

        if (cs_n) begin
            // Standby: counters cleared so a cut-short command leaves no trace
            d.state = SMSF_IDLE; // [R01] [R20]
            d.oe = 1'b0; // [R01]
            d.bcnt = BIT_FIRST; // [R20]
            d.fcnt = BIT_FIRST;
            d.acnt = ADDR_BYTE_FIRST;
        end else if (q.cs_f) begin
            // Fresh select: mode taken from the clock level
            d.mode3 = sck_n; // [R18] [R10]
            d.state = SMSF_OPC; // [R02] [R12]
            d.bcnt = BIT_FIRST; // [R11]
            d.fcnt = BIT_FIRST;
            d.acnt = ADDR_BYTE_FIRST;
            d.oe = 1'b0;
        end else begin
            // Receive only in input phases, data looked at on rise alone
            if (rise && (q.state == SMSF_OPC || q.state == SMSF_ADR ||
                         q.state == SMSF_DAT || q.state == SMSF_WSR)) begin // [R03] [R05] [R11]
                b = {q.rx, si_n}; // [R17]
                d.rx = b[6:0];
                d.bcnt = q.bcnt + 3'h1;
                if (q.bcnt == BIT_LAST) begin
                    case (q.state)
                        SMSF_OPC: begin
                            case (b)
                                OP_WR_EN: begin
                                    d.status[STAT_WEL_BIT] = 1'b1;
                                    d.state = SMSF_IGN;
                                end
                                OP_WR_DIS: begin
                                    d.status[STAT_WEL_BIT] = 1'b0;
                                    d.state = SMSF_IGN;
                                end
                                OP_RD_STAT: begin
                                    d.tx = q.status;
                                    d.rd_stat = 1'b1;
                                    d.state = SMSF_RD;
                                end
                                OP_WR_STAT: begin
                                    d.state = SMSF_WSR;
                                end
                                OP_WR_MEM, OP_RD_MEM: begin
                                    d.is_wr = (b == OP_WR_MEM);
                                    d.rd_stat = 1'b0;
                                    d.acnt = ADDR_BYTE_FIRST;
                                    d.state = SMSF_ADR; // [R12]
                                end
                                default: begin
                                    d.state = SMSF_IGN; // [R19]
                                end
                            endcase
                        end
                        SMSF_ADR: begin
                            // Shifting through a 19-bit register drops the top five bits
                            a = {q.addr[AW-BYTE_W-1:0], b}; // [R08]
                            d.addr = a;
                            d.acnt = q.acnt + 2'h1;
                            if (q.acnt == ADDR_BYTE_LAST) begin
                                if (q.is_wr) begin
                                    d.state = SMSF_DAT;
                                end else begin
                                    d.tx = mem[a];
                                    d.state = SMSF_RD;
                                end
                            end
                        end
                        SMSF_DAT: begin
                            // Byte lands in the array the moment it completes, but only while the enable latch is set
                            mem_we = q.status[STAT_WEL_BIT]; // [R09]
                            mem_wa = q.addr;
                            mem_wd = b;
                            d.addr = q.addr + 1'b1;
                        end
                        SMSF_WSR: begin
                            if (q.status[STAT_WEL_BIT] &&
                                !(q.status[STAT_PPE_BIT] && !q.wp_f)) begin // [R07]
                                d.status = (q.status & ~STAT_WR_MASK) | (b & STAT_WR_MASK);
                            end
                            d.state = SMSF_IGN;
                        end
                        default: begin
                            d.state = SMSF_IGN;
                        end
                    endcase
                end
            end
            // Read data leaves on falling edges, MSB first
            if (fall && q.state == SMSF_RD) begin // [R03] [R06] [R16] [R14]
                d.oe = 1'b1;
                d.so = q.tx[7]; // [R17]
                d.tx = {q.tx[6:0], 1'b0};
                d.fcnt = q.fcnt + 3'h1;
                if (q.fcnt == BIT_LAST) begin
                    if (q.rd_stat) begin
                        d.tx = q.status;
                    end else begin
                        d.tx = mem[q.addr + 1'b1];
                        d.addr = q.addr + 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Clock pauses are harmless: nothing moves without a sampled edge [R04]
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{sck_sy: '0, cs_sy: '1, si_sy: '0, wp_sy: '1, sck_f: 1'b0, cs_f: 1'b1,
                   si_f: 1'b0, wp_f: 1'b1, state: SMSF_IDLE, mode3: 1'b0, rx: '0,
                   bcnt: BIT_FIRST, acnt: ADDR_BYTE_FIRST, addr: '0, is_wr: 1'b0,
                   rd_stat: 1'b0, tx: 8'h00, fcnt: BIT_FIRST, status: STAT_RESET,
                   so: 1'b0, oe: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    // Array has no reset, as a nonvolatile store would not
    always_ff @(posedge clock) begin
        if (ce && mem_we) begin
            mem[mem_wa] <= mem_wd; // [R09]
        end
    end

    assign link.so_o = q.so;
    assign link.so_oe = q.oe;
    assign status_q_o = q.status;
    assign mode3_o = q.mode3;

endmodule

// ### hw/smsf_master.sv
// Master end: byte-level serial master that makes select and clock
`timescale 1ns/1ps
module smsf_master import smsf_pkg::*; #(
    parameter int HALF = SCK_HALF_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    smsf_link_if.mst link,
    input wire logic mode3_i,
    input wire logic wp_b_i,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic last,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte
);

    typedef struct packed {
        smsf_mst_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [2:0] bitn;
        logic [7:0] tx;
        logic [7:0] rx;
        logic last;
        logic mode3;
        logic cs_b;
        logic sck;
        logic si;
        logic wp_b;
        logic [SYNC_W-1:0] so_sy;
        logic so_f;
        logic done;
        logic [7:0] rx_out;
        logic busy;
    } smsf_mst_t;

    smsf_mst_t q;
    smsf_mst_t d;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic half_up;
        half_up = (q.cnt == CNT_W'(HALF - 1));
        d = q;
        d.done = 1'b0;
        d.wp_b = wp_b_i;
        d.so_sy = {q.so_sy[SYNC_W-2:0], link.miso};
        if (q.so_sy[1] == q.so_sy[2]) begin
            d.so_f = q.so_sy[2];
        end
        d.cnt = q.cnt + 1'b1;
        case (q.state)
            SMSF_M_IDLE: begin
                // Idle clock level tells the slave which mode is in use
                d.mode3 = mode3_i; // [R10]
                d.sck = mode3_i;
                d.cnt = '0;
                if (start) begin
                    d.cs_b = 1'b0; // [R15] [R02]
                    d.tx = tx_byte;
                    d.last = last;
                    d.busy = 1'b1;
                    d.state = SMSF_M_SETUP;
                end
            end
            SMSF_M_WAIT: begin
                d.cnt = '0;
                if (start) begin
                    d.tx = tx_byte;
                    d.last = last;
                    d.busy = 1'b1;
                    d.state = SMSF_M_SETUP;
                end
            end
            SMSF_M_SETUP: begin
                if (half_up) begin
                    d.cnt = '0;
                    d.bitn = BIT_FIRST;
                    d.state = SMSF_M_LOW;
                end
            end
            SMSF_M_LOW: begin
                d.sck = 1'b0;
                d.si = q.tx[7]; // [R17]
                if (half_up) begin
                    d.cnt = '0;
                    d.sck = 1'b1;
                    d.state = SMSF_M_HIGH;
                end
            end
            SMSF_M_HIGH: begin
                if (half_up) begin
                    // Sampled late in the high phase to absorb the slave's pin latency
                    d.rx = {q.rx[6:0], q.so_f}; // [R17]
                    d.tx = {q.tx[6:0], 1'b0};
                    d.cnt = '0;
                    d.bitn = q.bitn + 3'h1;
                    if (q.bitn == BIT_LAST) begin
                        d.sck = q.mode3;
                        d.rx_out = {q.rx[6:0], q.so_f};
                        if (q.last) begin
                            d.state = SMSF_M_HOLD;
                        end else begin
                            d.done = 1'b1;
                            d.busy = 1'b0;
                            d.state = SMSF_M_WAIT;
                        end
                    end else begin
                        d.sck = 1'b0;
                        d.state = SMSF_M_LOW;
                    end
                end
            end
            SMSF_M_HOLD: begin
                if (half_up) begin
                    d.cs_b = 1'b1; // [R13]
                    d.done = 1'b1;
                    d.busy = 1'b0;
                    d.state = SMSF_M_IDLE;
                end
            end
            default: begin
                d.state = SMSF_M_IDLE;
                d.cs_b = 1'b1;
            end
        endcase
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{state: SMSF_M_IDLE, cnt: '0, bitn: BIT_FIRST, tx: 8'h00, rx: 8'h00,
                   last: 1'b0, mode3: 1'b0, cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1,
                   so_sy: '1, so_f: 1'b1, done: 1'b0, rx_out: 8'h00, busy: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.cs_b = q.cs_b;
    assign link.sck = q.sck;
    assign link.mosi = q.si;
    assign link.wp_b = q.wp_b;
    assign busy = q.busy;
    assign done = q.done;
    assign rx_byte = q.rx_out;

endmodule

// ### testbench/smsf_link_sva.sv
// Concurrent checks on the serial link between the master and the memory front end
`timescale 1ns/1ps
module smsf_link_sva (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic mosi,
    input wire logic so_o,
    input wire logic so_oe
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic sck_q;
    logic cs_b_q;
    logic [3:0] rise_cnt_q;

    // Counts serial clock rises of the current frame, saturating once the opcode is in
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sck_q <= 1'b0;
            cs_b_q <= 1'b1;
            rise_cnt_q <= 4'h0;
        end else begin
            sck_q <= sck;
            cs_b_q <= cs_b;
            if (cs_b_q && !cs_b) begin
                rise_cnt_q <= 4'h0;
            end else if (!cs_b && sck && !sck_q && rise_cnt_q != 4'h8) begin
                rise_cnt_q <= rise_cnt_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Pin filtering lets the output trail a deselect by a few cycles only
    release_on_deselect_a: assert property (so_oe |-> !$past(cs_b, 6))
        else $error("output driven long after deselect");
    drive_on_fall_a: assert property ($rose(so_oe) |-> !sck)
        else $error("output enabled while serial clock high");
    out_change_low_a: assert property (so_oe && $changed(so_o) |-> !sck)
        else $error("output data moved while serial clock high");
    quiet_in_opcode_a: assert property ((rise_cnt_q < 4'h8) |-> !so_oe)
        else $error("output driven during opcode bits");
    select_setup_a: assert property ($fell(cs_b) |-> $stable(sck) [*8])
        else $error("serial clock moved right at select");
    high_phase_a: assert property ($rose(sck) |=> (sck && $stable(mosi)) [*7])
        else $error("data or clock unstable in high phase");
    deselect_idle_a: assert property ($rose(cs_b) |-> $stable(sck))
        else $error("deselect while serial clock moving");
    silent_standby_a: assert property (cs_b [*8] |-> !so_oe)
        else $error("output driven in standby");

    read_drive_c: cover property ($rose(so_oe));
    mode3_select_c: cover property ($fell(cs_b) && sck);
    mode0_select_c: cover property ($fell(cs_b) && !sck);
endmodule

// ### testbench/smsf_tb.sv
// Self-checking bench: master end and device end joined over the serial link
`timescale 1ns/1ps
module smsf_tb import smsf_pkg::*;;
    logic clock;
    logic rst_b;
    logic mode3;
    logic wp_b_i;
    logic ce;
    logic start;
    logic last;
    logic [7:0] tx_byte;
    logic busy;
    logic done;
    logic [7:0] rx_byte;
    logic [7:0] status;
    logic dev_mode3;
    logic [7:0] rx;
    int miscompares;
    int n_checks;
    logic [7:0] unknown_ops [3] = '{8'h0b, 8'h9f, 8'h42};

    smsf_link_if link();

    smsf_device u_smsf_device (
        .clock(clock), .rst_b(rst_b), .ce(ce), .link(link), .status_q_o(status), .mode3_o(dev_mode3)
    );

    smsf_master u_smsf_master (
        .clock(clock), .rst_b(rst_b), .ce(ce), .link(link), .mode3_i(mode3), .wp_b_i(wp_b_i),
        .start(start), .tx_byte(tx_byte), .last(last), .busy(busy), .done(done), .rx_byte(rx_byte)
    );

    smsf_link_sva u_smsf_link_sva (
        .clock(clock), .rst_b(rst_b), .cs_b(link.cs_b), .sck(link.sck), .mosi(link.mosi),
        .so_o(link.so_o), .so_oe(link.so_oe)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One byte through the master; start is raised one cycle after the previous done, or nine cycles after it when that byte was last
    task automatic xfer(input logic [7:0] b, input logic lst, output logic [7:0] got);
        int n;
        n = 0;
        @(posedge clock);
        start <= 1'b1;
        tx_byte <= b;
        last <= lst;
        @(posedge clock);
        start <= 1'b0;
        #1;
        chk({7'h00, busy}, 8'h01, "busy while shifting");
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: byte never completed", $time);
        end
        got = rx_byte;
        chk({7'h00, busy}, 8'h00, "busy after done");
        // Device sees the deselect through its pin filter, so let it settle
        if (lst) begin
            repeat (8) @(posedge clock);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic lst);
        logic [7:0] dummy;
        xfer(b, lst, dummy);
    endtask

    task automatic cmd_addr(input logic [7:0] op, input logic [23:0] a);
        send(op, 1'b0);
        send(a[23:16], 1'b0);
        send(a[15:8], 1'b0);
        send(a[7:0], 1'b0);
    endtask

    task automatic set_mode(input logic m);
        @(posedge clock);
        mode3 <= m;
        repeat (4) @(posedge clock);
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (80000) @(posedge clock);
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        mode3 = 1'b0;
        wp_b_i = 1'b1;
        ce = 1'b1;
        start = 1'b0;
        last = 1'b0;
        tx_byte = 8'h00;
        miscompares = 0;
        n_checks = 0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);

        chk(status, STAT_RESET, "status after reset");
        send(OP_WR_EN, 1'b1);
        chk(status, 8'h02, "enable latch");
        send(OP_WR_STAT, 1'b0);
        send(8'h8c, 1'b1);
        chk(status, 8'h8e, "status write");
        // Top five address bits set: must alias onto the low 19-bit location
        cmd_addr(OP_WR_MEM, 24'hf8_0010);
        send(8'ha5, 1'b0);
        send(8'h3c, 1'b1);
        $display("test mode0_write done");

        set_mode(1'b1);
        cmd_addr(OP_RD_MEM, 24'h00_0010);
        xfer(8'h00, 1'b0, rx);
        chk(rx, 8'ha5, "read byte 0");
        xfer(8'h00, 1'b1, rx);
        chk(rx, 8'h3c, "read byte 1");
        chk({7'h00, dev_mode3}, 8'h01, "mode latched");
        $display("test mode3_read done");

        @(posedge clock);
        wp_b_i <= 1'b0;
        send(OP_WR_STAT, 1'b0);
        send(8'h00, 1'b1);
        chk(status, 8'h8e, "protected status");
        send(OP_RD_STAT, 1'b0);
        xfer(8'h00, 1'b1, rx);
        chk(rx, 8'h8e, "status read");
        @(posedge clock);
        wp_b_i <= 1'b1;
        send(OP_WR_STAT, 1'b0);
        send(8'h00, 1'b1);
        chk(status, 8'h02, "unprotected status");
        $display("test protect done");

        set_mode(1'b0);
        foreach (unknown_ops[i]) begin
            send(unknown_ops[i], 1'b0);
            xfer(8'h00, 1'b1, rx);
            chk(rx, 8'hff, "released output");
        end
        $display("test unknown_opcode done");

        // Write cut off after its address: location must keep its data
        send(OP_WR_MEM, 1'b0);
        send(8'h00, 1'b0);
        send(8'h00, 1'b0);
        send(8'h10, 1'b1);
        chk(status, 8'h02, "status after abort");
        send(OP_WR_MEM, 1'b0);
        send(8'h00, 1'b1);
        cmd_addr(OP_RD_MEM, 24'h08_0010);
        xfer(8'h00, 1'b1, rx);
        chk(rx, 8'ha5, "data after abort");
        $display("test abort done");

        // With the enable latch clear a data byte must not land
        send(OP_WR_DIS, 1'b1);
        chk(status, 8'h00, "enable cleared");
        cmd_addr(OP_WR_MEM, 24'h00_0010);
        send(8'h77, 1'b1);
        cmd_addr(OP_RD_MEM, 24'h00_0010);
        xfer(8'h00, 1'b1, rx);
        chk(rx, 8'ha5, "write while disabled");
        $display("test disabled_write done");

        // Both ends frozen in mid-byte: the command must still complete intact
        fork
            send(OP_WR_EN, 1'b1);
            begin
                repeat (100) @(posedge clock);
                ce <= 1'b0;
                repeat (50) @(posedge clock);
                chk({7'h00, busy}, 8'h01, "busy while frozen");
                ce <= 1'b1;
            end
        join
        chk(status, 8'h02, "enable after freeze");
        $display("test freeze done");

        complete_run();
    end
endmodule
